/* adc_split_pkg.sv */
// constants and types shared by the output splitter and its helpers
// assumes one sample clock domain and an AXI4-Lite register master
package adc_split_pkg;

   // ************************************************************
   // widths
   // ************************************************************
   localparam int          DATA_W      = 8;
   localparam int          ADDR_W      = 8;
   localparam int          DLY_DEPTH   = 16;
   localparam int          SYNC_STAGES = 2;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0]  CTRL_OFS    = 8'h00;
   localparam logic [7:0]  STAT_OFS    = 8'h04;
   localparam int          CTRL_SPLIT  = 0;
   localparam int          CTRL_RATE   = 1;
   localparam logic        SPLIT_RST   = 1'b0;
   localparam logic        RATE_RST    = 1'b0;
   localparam int          STAT_STROBE = 0;
   localparam int          STAT_CNT    = 1;
   localparam int          STAT_RESET  = 3;
   localparam int          STAT_SWAL   = 4;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   // ************************************************************
   // latencies: the specified ones in half sample cycles, the rest in whole sample cycles
   // ************************************************************
   localparam int          PRI_LAT_HALF = 15;
   localparam int          AUX_LAT_HALF = 17;
   localparam int          RST_LAT_HALF = 13;
   localparam int          PRI_LAT_CYC  = (PRI_LAT_HALF + 1) / 2;
   localparam int          AUX_LAT_CYC  = (AUX_LAT_HALF + 1) / 2;
   localparam int          RST_LAT_CYC  = (RST_LAT_HALF + 1) / 2;
   localparam int          FULL_LAT_DEF = 8;
   localparam int          QPRI_LAT_DEF = 8;
   localparam int          QAUX_LAT_DEF = 9;
   localparam logic [1:0]  CNT_RST      = 2'h0;

   // ************************************************************
   // output rate modes
   // ************************************************************
   typedef enum logic [1:0] {
      RATE_FULL    = 2'h0,
      RATE_HALF    = 2'h1,
      RATE_QUARTER = 2'h3
   } rate_t;

endpackage : adc_split_pkg

/* level_sync.sv */
// two-flop synchroniser for pin levels
// assumes inputs are asynchronous to core_clk
`timescale 1ns/1ps
module level_sync #(
   parameter int W = 2
) (
   input  wire logic         core_clk,
   input  wire logic         rstn,
   input  wire logic [W-1:0] din,
   output logic      [W-1:0] dout
);
   import adc_split_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_t;

   sync_t s_q;
   sync_t s_d;

   always_comb begin
      s_d        = s_q;
      s_d.meta   = din;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dout = s_q.stable;

endmodule : level_sync

/* tap_delay.sv */
// shift register whose every stage is visible as a tap
// assumes din comes from logic on core_clk
`timescale 1ns/1ps
module tap_delay #(
   parameter int W     = 8,
   parameter int DEPTH = 16
) (
   input  wire logic                  core_clk,
   input  wire logic                  rstn,
   input  wire logic [W-1:0]          din,
   output logic      [DEPTH-1:0][W-1:0] taps
);
   import adc_split_pkg::*;

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] stage;
   } line_t;

   line_t s_q;
   line_t s_d;

   always_comb begin
      s_d          = s_q;
      s_d.stage[0] = din;
      for (int i = 1; i < DEPTH; i++) begin
         s_d.stage[i] = s_q.stage[i-1];
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign taps = s_q.stage;

endmodule : tap_delay

/* adc_split_out.sv */
// output splitter, strobe divider and aligned sync reset path
// assumes core_clk is the sample clock, samples arrive one per cycle
// from logic on core_clk, and software sets the mode over AXI4-Lite
`timescale 1ns/1ps
module adc_split_out #(
   parameter int FULL_LAT = adc_split_pkg::FULL_LAT_DEF,
   parameter int QPRI_LAT = adc_split_pkg::QPRI_LAT_DEF,
   parameter int QAUX_LAT = adc_split_pkg::QAUX_LAT_DEF
) (
   input  wire logic                             core_clk,
   input  wire logic                             rstn,
   // converter samples
   input  wire logic [adc_split_pkg::DATA_W-1:0] sample_data,
   // sync reset pins
   input  wire logic                             sync_reset_in_pos,
   input  wire logic                             sync_reset_in_neg,
   output logic                                  sync_reset_out_pos,
   output logic                                  sync_reset_out_neg,
   // output ports
   output logic                                  data_strobe,
   output logic      [adc_split_pkg::DATA_W-1:0] primary_data,
   output logic      [adc_split_pkg::DATA_W-1:0] aux_data,
   // axi4-lite slave
   input  wire logic [adc_split_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                             s_axi_awvalid,
   output logic                                  s_axi_awready,
   input  wire logic [31:0]                      s_axi_wdata,
   input  wire logic [3:0]                       s_axi_wstrb,
   input  wire logic                             s_axi_wvalid,
   output logic                                  s_axi_wready,
   output logic      [1:0]                       s_axi_bresp,
   output logic                                  s_axi_bvalid,
   input  wire logic                             s_axi_bready,
   input  wire logic [adc_split_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                             s_axi_arvalid,
   output logic                                  s_axi_arready,
   output logic      [31:0]                      s_axi_rdata,
   output logic      [1:0]                       s_axi_rresp,
   output logic                                  s_axi_rvalid,
   input  wire logic                             s_axi_rready
);
   import adc_split_pkg::*;

   // ************************************************************
   // tap positions
   // ************************************************************
   // data: shift stage plus output flop; reset: sync, stage, output
   localparam logic [3:0] HPRI_TAP = 4'(PRI_LAT_CYC - 2);
   localparam logic [3:0] HAUX_TAP = 4'(AUX_LAT_CYC - 2);
   localparam logic [3:0] FPRI_TAP = 4'(FULL_LAT - 2);
   localparam logic [3:0] QPRI_TAP = 4'(QPRI_LAT - 2);
   localparam logic [3:0] QAUX_TAP = 4'(QAUX_LAT - 2);
   localparam logic [3:0] RST_TAP  = 4'(RST_LAT_CYC - SYNC_STAGES - 2);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic              awready;
      logic              wready;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              aw_got;
      logic              w_got;
      logic [ADDR_W-1:0] awaddr;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              arready;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [31:0]       rdata;
      logic              split_en;
      logic              rate_sel;
      logic [1:0]        cnt;
      logic [1:0]        expect_cnt;
      logic              rst_prev;
      logic              swal_seen;
      logic              swal_last;
      logic              strobe;
      logic [DATA_W-1:0] pri;
      logic [DATA_W-1:0] aux;
      logic              rout_p;
      logic              rout_n;
   } state_t;

   state_t s_q;
   state_t s_d;

   // ************************************************************
   // reset pin capture and delay lines
   // ************************************************************
   logic [1:0]                     rst_pins;
   logic                           rst_cap;
   logic                           rst_feed;
   logic [DLY_DEPTH-1:0][0:0]      rst_taps;
   logic [DLY_DEPTH-1:0][DATA_W-1:0] data_taps;

   level_sync #(
      .W (2)
   ) u_rst_sync (
      .core_clk (core_clk),
      .rstn     (rstn),
      .din      ({sync_reset_in_pos, sync_reset_in_neg}),
      .dout     (rst_pins)
   );

   assign rst_cap = rst_pins[1] & ~rst_pins[0];

   tap_delay #(
      .W     (DATA_W),
      .DEPTH (DLY_DEPTH)
   ) u_data_line (
      .core_clk (core_clk),
      .rstn     (rstn),
      .din      (sample_data),
      .taps     (data_taps)
   );

   tap_delay #(
      .W     (1),
      .DEPTH (DLY_DEPTH)
   ) u_rst_line (
      .core_clk (core_clk),
      .rstn     (rstn),
      .din      (rst_feed),
      .taps     (rst_taps)
   );

   // ************************************************************
   // mode and divider control
   // ************************************************************
   rate_t      mode;
   logic [1:0] wrap;
   logic [1:0] exp_now;
   logic       rst_rise;
   logic       swallow;
   logic [3:0] pri_tap;
   logic [3:0] aux_tap;

   always_comb begin
      mode    = RATE_FULL;
      wrap    = 2'h0;
      pri_tap = FPRI_TAP;
      aux_tap = FPRI_TAP;
      if (s_q.split_en) begin
         if (s_q.rate_sel) begin
            mode    = RATE_QUARTER;
            wrap    = 2'h3;
            pri_tap = QPRI_TAP;
            aux_tap = QAUX_TAP;
         end else begin
            mode    = RATE_HALF;
            wrap    = 2'h1;
            pri_tap = HPRI_TAP;
            aux_tap = HAUX_TAP;
         end
      end
   end

   assign rst_rise = rst_cap & ~s_q.rst_prev;
   assign exp_now  = rst_rise ? CNT_RST : s_q.expect_cnt;
   assign swallow  = rst_cap && (mode != RATE_FULL)
                     && (s_q.cnt != exp_now);
   assign rst_feed = rst_cap & ~swallow & ~s_q.swal_seen;

   // ************************************************************
   // next state
   // ************************************************************
   logic aw_sel_ctrl;
   logic aw_sel_stat;
   logic ar_sel_ctrl;
   logic ar_sel_stat;
   logic do_write;
   logic strobe_rise;

   always_comb begin
      s_d         = s_q;
      aw_sel_ctrl = (s_q.awaddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]);
      aw_sel_stat = (s_q.awaddr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);
      ar_sel_ctrl = (s_axi_araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2]);
      ar_sel_stat = (s_axi_araddr[ADDR_W-1:2] == STAT_OFS[ADDR_W-1:2]);
      do_write    = s_q.aw_got & s_q.w_got & ~s_q.bvalid;
      strobe_rise = 1'b0;

      // write address and data, taken in either order
      if (s_axi_awvalid & s_q.awready) begin
         s_d.aw_got = 1'b1;
         s_d.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_q.wready) begin
         s_d.w_got = 1'b1;
         s_d.wdata = s_axi_wdata;
         s_d.wstrb = s_axi_wstrb;
      end
      if (s_q.bvalid & s_axi_bready) begin
         s_d.bvalid = 1'b0;
      end
      if (do_write) begin
         s_d.aw_got = 1'b0;
         s_d.w_got  = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp  = RESP_OKAY;
         if (aw_sel_ctrl) begin
            if (s_q.wstrb[0]) begin
               s_d.split_en = s_q.wdata[CTRL_SPLIT];
               s_d.rate_sel = s_q.wdata[CTRL_RATE];
            end
         end else if (!aw_sel_stat) begin
            s_d.bresp = RESP_SLVERR;
         end
      end
      s_d.awready = ~s_d.aw_got & ~s_d.bvalid;
      s_d.wready  = ~s_d.w_got & ~s_d.bvalid;

      // read channel
      if (s_q.rvalid & s_axi_rready) begin
         s_d.rvalid = 1'b0;
      end
      if (s_axi_arvalid & s_q.arready) begin
         s_d.rvalid = 1'b1;
         s_d.rresp  = RESP_OKAY;
         s_d.rdata  = 32'h0;
         if (ar_sel_ctrl) begin
            s_d.rdata[CTRL_SPLIT] = s_q.split_en;
            s_d.rdata[CTRL_RATE]  = s_q.rate_sel;
         end else if (ar_sel_stat) begin
            s_d.rdata[STAT_STROBE]           = s_q.strobe;
            s_d.rdata[STAT_CNT+1:STAT_CNT]   = s_q.cnt;
            s_d.rdata[STAT_RESET]            = rst_cap;
            s_d.rdata[STAT_SWAL]             = s_q.swal_last;
         end else begin
            s_d.rresp = RESP_SLVERR;
         end
      end
      s_d.arready = ~s_d.rvalid;

      // divider: hold one cycle per mismatch while reset is captured
      s_d.rst_prev = rst_cap;
      if (mode == RATE_FULL) begin
         s_d.cnt = CNT_RST;
      end else if (swallow) begin
         s_d.cnt = s_q.cnt;
      end else if (s_q.cnt >= wrap) begin
         s_d.cnt = CNT_RST;
      end else begin
         s_d.cnt = s_q.cnt + 2'h1;
      end
      s_d.expect_cnt = (exp_now >= wrap) ? CNT_RST : exp_now + 2'h1;

      // swallowed flag: set wins over the clear on a new reset
      if (!rst_cap) begin
         s_d.swal_seen = 1'b0;
      end else if (swallow) begin
         s_d.swal_seen = 1'b1;
      end
      if (swallow) begin
         s_d.swal_last = 1'b1;
      end else if (rst_rise) begin
         s_d.swal_last = 1'b0;
      end

      // strobe: toggles at full rate, else follows the divider count and holds while a swallow holds it
      case (mode)
         RATE_FULL: begin
            s_d.strobe  = ~s_q.strobe;
            strobe_rise = 1'b1;
         end
         RATE_HALF: begin
            s_d.strobe  = (s_d.cnt == CNT_RST);
            strobe_rise = s_d.strobe & ~s_q.strobe;
         end
         RATE_QUARTER: begin
            s_d.strobe  = ~s_d.cnt[1];
            strobe_rise = s_d.strobe & ~s_q.strobe;
         end
         default: begin
            s_d.strobe  = 1'b0;
            strobe_rise = 1'b0;
         end
      endcase

      // ports update with the strobe rising edge, or every cycle at full rate
      if (strobe_rise) begin
         s_d.pri = data_taps[pri_tap];
         if (mode == RATE_FULL) begin
            s_d.aux = '0;
         end else begin
            s_d.aux = data_taps[aux_tap];
         end
      end

      // reset output, time aligned to port data
      s_d.rout_p = rst_taps[RST_TAP][0];
      s_d.rout_n = ~rst_taps[RST_TAP][0];
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         s_q          <= '0;
         s_q.split_en <= SPLIT_RST;
         s_q.rate_sel <= RATE_RST;
         s_q.cnt      <= CNT_RST;
         s_q.rout_n   <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign sync_reset_out_pos = s_q.rout_p;
   assign sync_reset_out_neg = s_q.rout_n;
   assign data_strobe        = s_q.strobe;
   assign primary_data       = s_q.pri;
   assign aux_data           = s_q.aux;
   assign s_axi_awready      = s_q.awready;
   assign s_axi_wready       = s_q.wready;
   assign s_axi_bresp        = s_q.bresp;
   assign s_axi_bvalid       = s_q.bvalid;
   assign s_axi_arready      = s_q.arready;
   assign s_axi_rdata        = s_q.rdata;
   assign s_axi_rresp        = s_q.rresp;
   assign s_axi_rvalid       = s_q.rvalid;

endmodule : adc_split_out

/* adc_split_sva.sv */
// concurrent checks on the output splitter ports
// assumes one sample clock and a bind into every adc_split_out
`timescale 1ns/1ps
module adc_split_sva #(
   parameter int FULL_LAT = adc_split_pkg::FULL_LAT_DEF,
   parameter int QPRI_LAT = adc_split_pkg::QPRI_LAT_DEF,
   parameter int QAUX_LAT = adc_split_pkg::QAUX_LAT_DEF
) (
   input wire logic        core_clk,
   input wire logic        rstn,
   input wire logic [7:0]  sample_data,
   input wire logic        sync_reset_in_pos,
   input wire logic        sync_reset_in_neg,
   input wire logic        sync_reset_out_pos,
   input wire logic        sync_reset_out_neg,
   input wire logic        data_strobe,
   input wire logic [7:0]  primary_data,
   input wire logic [7:0]  aux_data,
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid
);
   import adc_split_pkg::*;
   // ********************
   // mode and quiet tracking
   // ********************
   logic       pin_on;
   logic       run;
   logic [1:0] mode_q;
   logic [4:0] settle_q;
   logic [4:0] quiet_q;

   assign pin_on = sync_reset_in_pos & ~sync_reset_in_neg;
   assign run    = settle_q > 5'h17 && quiet_q > 5'h17;

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         mode_q   <= 2'h0;
         settle_q <= 5'h0;
         quiet_q  <= 5'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
             && s_axi_awaddr == CTRL_OFS && s_axi_wstrb[0]) begin
            mode_q   <= s_axi_wdata[1:0];
            settle_q <= 5'h0;
         end else if (settle_q != 5'h1f) begin
            settle_q <= settle_q + 5'h1;
         end
         if (pin_on) begin
            quiet_q <= 5'h0;
         end else if (quiet_q != 5'h1f) begin
            quiet_q <= quiet_q + 5'h1;
         end
      end
   end
   // ********************
   // assertions
   // ********************
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rstn);

   pri_half_a: assert property (
      run && mode_q == 2'h1 && $rose(data_strobe)
      |-> primary_data == $past(sample_data, PRI_LAT_CYC))
      else $error("primary latency wrong at half rate");
   aux_half_a: assert property (
      run && mode_q == 2'h1 && $rose(data_strobe)
      |-> aux_data == $past(sample_data, AUX_LAT_CYC))
      else $error("aux latency or order wrong at half rate");
   data_edge_a: assert property (
      run && mode_q[0] && $changed(primary_data) |-> $rose(data_strobe))
      else $error("port data changed off the strobe rise");
   full_rate_a: assert property (
      run && !mode_q[0] |-> primary_data == $past(sample_data, FULL_LAT)
      && aux_data == 8'h0)
      else $error("full rate port data wrong");
   quarter_rate_a: assert property (
      run && mode_q == 2'h3 && $rose(data_strobe)
      |-> primary_data == $past(sample_data, QPRI_LAT)
      && aux_data == $past(sample_data, QAUX_LAT))
      else $error("quarter rate port data wrong");
   half_toggle_a: assert property (
      run && mode_q == 2'h1 |-> $changed(data_strobe))
      else $error("half rate strobe did not toggle");
   rst_rise_a: assert property (
      $rose(sync_reset_out_pos) |-> $past(pin_on, RST_LAT_CYC)
      && !$past(pin_on, RST_LAT_CYC + 1))
      else $error("reset output rose at wrong time");
   rst_fall_a: assert property (
      $fell(sync_reset_out_pos) |-> !$past(pin_on, RST_LAT_CYC)
      && $past(pin_on, RST_LAT_CYC + 1))
      else $error("reset output fell at wrong time");
   rst_pair_a: assert property (
      sync_reset_out_neg == !sync_reset_out_pos)
      else $error("reset output pair not complementary");
   rst_clocked_a: assert property (
      sync_reset_out_pos |-> ##[0:1] $changed(data_strobe))
      else $error("strobe stopped during reset output");
   rd_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   rd_unmapped_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr != CTRL_OFS
      && s_axi_araddr != STAT_OFS
      |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
   wr_answer_a: assert property (
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid)
      else $error("write answer late");
endmodule : adc_split_sva

bind adc_split_out adc_split_sva #(
   .FULL_LAT(FULL_LAT), .QPRI_LAT(QPRI_LAT), .QAUX_LAT(QAUX_LAT)
) chk (
   .core_clk, .rstn, .sample_data, .sync_reset_in_pos, .sync_reset_in_neg,
   .sync_reset_out_pos, .sync_reset_out_neg, .data_strobe, .primary_data,
   .aux_data, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
   .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid
);

/* far_side_model.sv */
// far side: sync reset controller and clocked downstream splitter
// assumes pins change just after the core_clk rising edge
`timescale 1ns/1ps
module far_side_model (
   input  wire logic       core_clk,
   input  wire logic       go,
   input  wire logic [2:0] len,
   input  wire logic       rst_out,
   input  wire logic       strobe,
   output logic            pin_pos = 1'b0,
   output logic            pin_neg = 1'b1,
   output logic [7:0]      rise_at = 8'h0,
   output logic [7:0]      high_cnt = 8'h0,
   output logic [7:0]      tog_cnt = 8'h0
);
   logic [2:0] left = 3'h0;
   logic [7:0] since = 8'h0;
   logic       rst_d = 1'b0;
   logic       stb_d = 1'b0;

   always @(posedge core_clk) begin
      stb_d <= strobe;
      rst_d <= rst_out;
      if (since != 8'hff) since <= since + 8'h1;
      if (rst_out && !rst_d) rise_at <= since;
      if (rst_out) high_cnt <= high_cnt + 8'h1;
      if (rst_out && strobe != stb_d) tog_cnt <= tog_cnt + 8'h1;
      if (go) begin
         left     <= len - 3'h1;
         pin_pos  <= 1'b1;
         pin_neg  <= 1'b0;
         since    <= 8'h0;
         high_cnt <= 8'h0;
         tog_cnt  <= 8'h0;
      end else if (left != 3'h0) begin
         left <= left - 3'h1;
      end else begin
         pin_pos <= 1'b0;
         pin_neg <= 1'b1;
      end
   end
endmodule : far_side_model

/* tb.sv */
// self-checking bench for the output splitter
// assumes adc_split_sva is bound in and far_side_model drives the pins
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fails++; \
   $display("MISMATCH t=%0t got %0h exp %0h", $time, a, b); end end
module tb;
   import adc_split_pkg::*;
   logic        core_clk = 1'b0, rstn = 1'b0, go = 1'b0;
   logic [2:0]  len = 3'h1;
   logic [7:0]  sample_data = 8'h0, rnd = 8'h38, awaddr = 8'h0;
   logic [7:0]  araddr = 8'h0, primary_data, aux_data;
   logic [7:0]  rise_at, high_cnt, tog_cnt;
   logic [31:0] wdata = 32'h0, rdata;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, strobe;
   logic        pin_pos, pin_neg, rst_pos, rst_neg;
   logic [1:0]  bresp, rresp, mode;
   int          fails = 0, n_tests = 0;

   initial forever #12.5 core_clk = ~core_clk;

   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr

   always @(posedge core_clk) begin
      rnd         <= lfsr(rnd);
      sample_data <= rnd;
   end

   adc_split_out dut (
      .core_clk(core_clk), .rstn(rstn), .sample_data(sample_data),
      .sync_reset_in_pos(pin_pos), .sync_reset_in_neg(pin_neg),
      .sync_reset_out_pos(rst_pos), .sync_reset_out_neg(rst_neg),
      .data_strobe(strobe), .primary_data(primary_data),
      .aux_data(aux_data), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready)
   );

   far_side_model far (
      .core_clk(core_clk), .go(go), .len(len), .rst_out(rst_pos),
      .strobe(strobe), .pin_pos(pin_pos), .pin_neg(pin_neg),
      .rise_at(rise_at), .high_cnt(high_cnt), .tog_cnt(tog_cnt)
   );

   task automatic results();
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : results

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [1:0] r);
      bit ta, tw, got;
      got = 0;
      @(posedge core_clk);
      awaddr  <= a;
      wdata   <= d;
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      for (int i = 0; i < 40 && !got; i++) begin
         @(negedge core_clk);
         ta  = awvalid && awready;
         tw  = wvalid && wready;
         got = bvalid;
         r   = bresp;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      if (!got) fails++;
      if (!got) results();
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
      bit ta, got;
      got = 0;
      @(posedge core_clk);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      for (int i = 0; i < 40 && !got; i++) begin
         @(negedge core_clk);
         ta  = arvalid && arready;
         got = rvalid;
         d   = rdata;
         r   = rresp;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      if (!got) fails++;
      if (!got) results();
   endtask : rd

   task automatic pulse(input int gap, input logic [2:0] n,
                        output bit seen, output bit ph);
      logic [31:0] d;
      logic [1:0]  r;
      repeat (gap) @(posedge core_clk);
      go  <= 1'b1;
      len <= n;
      @(posedge core_clk);
      go <= 1'b0;
      repeat (40) @(posedge core_clk);
      @(negedge core_clk);
      ph   = strobe;
      seen = high_cnt != 8'h0;
      rd(STAT_OFS, d, r);
      `CHK(d[STAT_SWAL], !seen)
      if (seen) `CHK(high_cnt, {5'h0, n})
      if (seen) `CHK(rise_at, 8'(RST_LAT_CYC))
      if (seen && mode != 2'h3) `CHK(tog_cnt, high_cnt)
   endtask : pulse

   initial begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [7:0]  pick;
      bit          s0, s1, p, p_ref, have_ref;
      pick = 8'h38;
      mode = 2'h0;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      rd(CTRL_OFS, d, r);
      `CHK(d, 32'h0)
      rd(8'h08, d, r);
      `CHK(r, RESP_SLVERR)
      wr(8'h0c, 32'h1, 4'hf, r);
      `CHK(r, RESP_SLVERR)
      wr(STAT_OFS, 32'h1f, 4'hf, r);
      `CHK(r, RESP_OKAY)
      wr(CTRL_OFS, 32'hffff_ffff, 4'h0, r);
      rd(CTRL_OFS, d, r);
      `CHK(d, 32'h0)
      for (int m = 0; m < 3; m++) begin
         mode = (m == 0) ? 2'h2 : (m == 1) ? 2'h1 : 2'h3;
         wr(CTRL_OFS, {30'h3fff_ffff, mode}, 4'h1, r);
         rd(CTRL_OFS, d, r);
         `CHK(d, {30'h0, mode})
         have_ref = 0;
         for (int k = 0; k < 6; k++) begin
            pick = lfsr(pick);
            pulse(20 + pick[3:0], {1'b0, pick[5:4]} + 3'h1, s0, p);
            if (mode == 2'h1 && have_ref) `CHK(p, p_ref)
            if (!mode[0]) `CHK(s0, 1'b1)
            p_ref    = have_ref ? p_ref : p;
            have_ref = 1;
         end
         if (mode == 2'h1) begin
            pulse(40, 3'h2, s0, p);
            pulse(41, 3'h2, s1, p);
            `CHK(s0 ^ s1, 1'b1)
            `CHK(p, p_ref)
         end
      end
      results();
   end
endmodule : tb
